// File: ctec_top.sv
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
//Contract
// - unit enable bit turns the unit on; clear holds it off, but discharge, trim and range still follow their registers.
// - stop-in-idle set halts the unit while the device is idle.
// - delay generation bit switches edge-delayed pulse generation on or off.
// - edge gate bit passes selected edges; clear blocks all edges.
// - order bit makes second edge wait for the first edge.
// - discharge bit grounds the current source output.
// - trigger enable bit enables the trigger output.
// - unimplemented bits read zero, ignore writes; all fields reset to zero.
// - first edge sensitivity: set for transitions, clear for levels.
// - first edge polarity: set rising, clear falling.
// - first edge source select maps comparators, captures, pins, compare, timer.
// - second edge source select map; code 1100 has no source.
// - first edge flag sets on a qualified first edge.
// - second edge flag sets on a qualified second edge.
// - software writes to both flags steer the current source directly.
// - second edge sensitivity: set for transitions, clear for levels.
// - second edge polarity set selects rising response.
// - six-bit trim is a signed offset from nominal current.
// - two-bit range selects base, ten, hundred or thousand times base.
// - measurement pulse spans the first to second edge interval.
// - equal flags route the current source to the temperature diode.
// - delay mode charges on edge, pulses when comparator trips.
module ctec_top (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [1:0]  regAddr,
    input  wire logic [15:0] regWriteData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic [15:0]      regReadData,
    input  wire logic        deviceIdle,
    input  wire logic        timerOne,
    input  wire logic        outputCompareOne,
    input  wire logic [12:0] externalEdgePin,
    input  wire logic [2:0]  inputCapture,
    input  wire logic [2:0]  comparatorOut,
    input  wire logic        delayTrip,
    output logic             currentSourceOn,
    output logic             currentDischarge,
    output logic             diodeRoute,
    output logic [5:0]       currentTrim,
    output logic [1:0]       currentRange,
    output logic [1:0]       rangeDecade,
    output logic             measurePulse,
    output logic             triggerOut,
    output logic             delayCharge,
    output logic             delayedPulseOutput
);
    typedef struct packed {
        logic [15:0]       ctl1;
        logic [15:0]       ctl2;
        logic [15:0]       icon;
        logic [15:0]       readData;
        logic              measure;
        logic              trigger;
        ctec_pkg::ctec_dg_t dgState;
        logic              delayPulse;
    } ctec_state_t;

    ctec_state_t s_r;
    ctec_state_t s_nxt;

    logic       unitEnable;
    logic       running;
    logic       edgeGate;
    logic       firstFlag;
    logic       secondFlag;
    logic       firstSource;
    logic       secondSource;
    logic       firstRaw;
    logic       secondRaw;
    logic       firstEvent;
    logic       secondEvent;
    logic       wrCtl1;
    logic       wrCtl2;
    logic       wrIcon;

    // field views of the stored registers
    assign unitEnable = s_r.ctl1[ctec_pkg::B_UNIT_ENABLE];
    assign firstFlag  = s_r.ctl2[ctec_pkg::B_FIRST_FLAG];
    assign secondFlag = s_r.ctl2[ctec_pkg::B_SECOND_FLAG];

    // unit runs when enabled and not parked by idle
    assign running  = unitEnable & ~(s_r.ctl1[ctec_pkg::B_STOP_IN_IDLE] & deviceIdle);
    assign edgeGate = running & s_r.ctl1[ctec_pkg::B_EDGE_GATE];

    // register port write decode
    assign wrCtl1 = regWrite && (regAddr == ctec_pkg::IDX_MEASURE_CONTROL_ONE);
    assign wrCtl2 = regWrite && (regAddr == ctec_pkg::IDX_EDGE_CONTROL_TWO);
    assign wrIcon = regWrite && (regAddr == ctec_pkg::IDX_CURRENT_SOURCE_CONTROL);

    // source selection for each edge channel
    ctec_source_mux #(
        .SECOND (1'b0)
    ) u_first_mux (
        .select           (s_r.ctl2[ctec_pkg::B_FIRST_SRC_LO +: 4]),
        .timerOne         (timerOne),
        .outputCompareOne (outputCompareOne),
        .externalEdgePin  (externalEdgePin),
        .inputCapture     (inputCapture),
        .comparatorOut    (comparatorOut),
        .source           (firstSource)
    );

    ctec_source_mux #(
        .SECOND (1'b1)
    ) u_second_mux (
        .select           (s_r.ctl2[ctec_pkg::B_SECOND_SRC_LO +: 4]),
        .timerOne         (timerOne),
        .outputCompareOne (outputCompareOne),
        .externalEdgePin  (externalEdgePin),
        .inputCapture     (inputCapture),
        .comparatorOut    (comparatorOut),
        .source           (secondSource)
    );

    // sensitivity and polarity qualification per channel
    ctec_edge_qual u_first_qual (
        .clock     (clock),
        .reset     (reset),
        .source    (firstSource),
        .edgeMode  (s_r.ctl2[ctec_pkg::B_FIRST_SENS]),
        .risingPol (s_r.ctl2[ctec_pkg::B_FIRST_POL]),
        .event_o   (firstRaw)
    );

    ctec_edge_qual u_second_qual (
        .clock     (clock),
        .reset     (reset),
        .source    (secondSource),
        .edgeMode  (s_r.ctl2[ctec_pkg::B_SECOND_SENS]),
        .risingPol (s_r.ctl2[ctec_pkg::B_SECOND_POL]),
        .event_o   (secondRaw)
    );

    // gated events; second waits for first when ordering is on
    assign firstEvent  = edgeGate & firstRaw;
    assign secondEvent = edgeGate & secondRaw & (~s_r.ctl1[ctec_pkg::B_EDGE_ORDER] | firstFlag);

    // decade of the selected current range
    function automatic logic [1:0] decade(input logic [1:0] rng);
        case (rng)
            ctec_pkg::RNG_BASE:     decade = ctec_pkg::DEC_ZERO;
            ctec_pkg::RNG_TEN:      decade = ctec_pkg::DEC_ONE;
            ctec_pkg::RNG_HUNDRED:  decade = ctec_pkg::DEC_TWO;
            ctec_pkg::RNG_THOUSAND: decade = ctec_pkg::DEC_THREE;
            default:                decade = ctec_pkg::DEC_ZERO;
        endcase
    endfunction

    // next state of registers, flags, pulses and delay sequencer
    always_comb begin
        s_nxt = s_r;
        if (wrCtl1) begin
            s_nxt.ctl1 = regWriteData & ctec_pkg::MASK_CTL1;
        end
        if (wrCtl2) begin
            s_nxt.ctl2 = regWriteData & ctec_pkg::MASK_CTL2;
        end
        if (wrIcon) begin
            s_nxt.icon = regWriteData & ctec_pkg::MASK_ICON;
        end
        // hardware set wins over a software clear in the same cycle
        if (firstEvent) begin
            s_nxt.ctl2[ctec_pkg::B_FIRST_FLAG] = 1'b1;
        end
        if (secondEvent) begin
            s_nxt.ctl2[ctec_pkg::B_SECOND_FLAG] = 1'b1;
        end
        // read data stand only in the cycle after the strobe
        s_nxt.readData = ctec_pkg::RESET_ZERO;
        if (regRead) begin
            case (regAddr)
                ctec_pkg::IDX_MEASURE_CONTROL_ONE:    s_nxt.readData = s_r.ctl1;
                ctec_pkg::IDX_EDGE_CONTROL_TWO:       s_nxt.readData = s_r.ctl2;
                ctec_pkg::IDX_CURRENT_SOURCE_CONTROL: s_nxt.readData = s_r.icon;
                default:                              s_nxt.readData = ctec_pkg::RESET_ZERO;
            endcase
        end
        // window between first and second edge
        s_nxt.measure = running & firstFlag & ~secondFlag;
        // one-cycle trigger when the second edge lands
        s_nxt.trigger = secondEvent & ~secondFlag & s_r.ctl1[ctec_pkg::B_TRIGGER_ENABLE];
        // delay generation: charge on edge, fire on trip
        s_nxt.delayPulse = 1'b0;
        case (s_r.dgState)
            ctec_pkg::DG_IDLE: begin
                if (running && s_r.ctl1[ctec_pkg::B_DELAY_GEN] && firstEvent) begin
                    s_nxt.dgState = ctec_pkg::DG_CHARGE;
                end
            end
            ctec_pkg::DG_CHARGE: begin
                if (!running || !s_r.ctl1[ctec_pkg::B_DELAY_GEN]) begin
                    s_nxt.dgState = ctec_pkg::DG_IDLE;
                end else if (delayTrip) begin
                    s_nxt.dgState    = ctec_pkg::DG_FIRE;
                    s_nxt.delayPulse = 1'b1;
                end
            end
            ctec_pkg::DG_FIRE: begin
                s_nxt.dgState = ctec_pkg::DG_IDLE;
            end
            default: begin
                s_nxt.dgState = ctec_pkg::DG_IDLE;
            end
        endcase
    end

    // state register, every field clears on reset
    always_ff @(posedge clock) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // source on and diode route follow the flags; the other outputs come from registered state
    assign currentSourceOn    = running & (firstFlag ^ secondFlag);
    assign diodeRoute         = running & (firstFlag == secondFlag);
    assign currentDischarge   = s_r.ctl1[ctec_pkg::B_DISCHARGE];
    assign currentTrim        = s_r.icon[ctec_pkg::B_TRIM_LO +: 6];
    assign currentRange       = s_r.icon[ctec_pkg::B_RANGE_LO +: 2];
    assign rangeDecade        = decade(currentRange);
    assign measurePulse       = s_r.measure;
    assign triggerOut         = s_r.trigger;
    assign delayCharge        = (s_r.dgState == ctec_pkg::DG_CHARGE);
    assign delayedPulseOutput = s_r.delayPulse;
    assign regReadData        = s_r.readData;

    // checks on the behaviour above
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_first_flag_set: assert property (firstEvent |=> firstFlag)
        else $error("first edge flag not set after event");

    a_second_flag_set: assert property (secondEvent |=> secondFlag)
        else $error("second edge flag not set after event");

    a_order_holds: assert property (
        (s_r.ctl1[ctec_pkg::B_EDGE_ORDER] && !firstFlag && !secondFlag && !wrCtl2)
        |-> !secondEvent)
        else $error("second edge accepted before first");

    a_gate_blocks: assert property (
        !s_r.ctl1[ctec_pkg::B_EDGE_GATE] |-> !firstEvent && !secondEvent)
        else $error("edge passed while gate closed");

    a_idle_halt: assert property (
        (unitEnable && s_r.ctl1[ctec_pkg::B_STOP_IN_IDLE] && deviceIdle) |=> !measurePulse)
        else $error("measurement ran during idle");

    a_disabled_quiet: assert property (
        !unitEnable |-> !currentSourceOn && !diodeRoute && !firstEvent)
        else $error("disabled unit is active");

    a_diode_route: assert property (
        (running && firstFlag == secondFlag) |-> diodeRoute && !currentSourceOn)
        else $error("equal flags not routed to diode");

    a_flag_write: assert property (
        (wrCtl2 && !firstEvent && !secondEvent) |=>
        {secondFlag, firstFlag} == $past(regWriteData[ctec_pkg::B_SECOND_FLAG -: 2]))
        else $error("flag write not taken");

    a_unimpl_zero: assert property (
        regRead |=> (regReadData & ~(ctec_pkg::MASK_CTL1 | ctec_pkg::MASK_CTL2)) == 16'h0000)
        else $error("unimplemented bits read nonzero");

    a_delay_pulse: assert property (
        (delayCharge && running && s_r.ctl1[ctec_pkg::B_DELAY_GEN] && delayTrip)
        |=> delayedPulseOutput ##1 (!delayedPulseOutput && !delayCharge))
        else $error("delayed pulse not one cycle after trip");

    a_measure_span: assert property (
        (running && firstFlag && !secondFlag) |=> measurePulse)
        else $error("measurement pulse missing in window");

    a_trigger_off: assert property (
        !s_r.ctl1[ctec_pkg::B_TRIGGER_ENABLE] |=> !triggerOut)
        else $error("trigger while disabled");

endmodule // ctec_top
`default_nettype wire

// File: ctec_pkg.sv
// shared constants for the charge timing edge control block
package ctec_pkg;

    // register port geometry
    localparam int unsigned ADDR_W = 2;
    localparam int unsigned DATA_W = 16;

    // register indices on the plain register port
    localparam logic [1:0] IDX_MEASURE_CONTROL_ONE    = 2'h0;
    localparam logic [1:0] IDX_EDGE_CONTROL_TWO       = 2'h1;
    localparam logic [1:0] IDX_CURRENT_SOURCE_CONTROL = 2'h2;

    // implemented bits of each register, all others read zero
    localparam logic [15:0] MASK_CTL1 = 16'hBF00;
    localparam logic [15:0] MASK_CTL2 = 16'hFFFC;
    localparam logic [15:0] MASK_ICON = 16'hFF00;
    localparam logic [15:0] RESET_ZERO = 16'h0000;

    // measure_control_one fields
    localparam int unsigned B_UNIT_ENABLE     = 15;
    localparam int unsigned B_STOP_IN_IDLE    = 13;
    localparam int unsigned B_DELAY_GEN       = 12;
    localparam int unsigned B_EDGE_GATE       = 11;
    localparam int unsigned B_EDGE_ORDER      = 10;
    localparam int unsigned B_DISCHARGE       = 9;
    localparam int unsigned B_TRIGGER_ENABLE  = 8;

    // edge_control_two fields
    localparam int unsigned B_FIRST_SENS      = 15;
    localparam int unsigned B_FIRST_POL       = 14;
    localparam int unsigned B_FIRST_SRC_LO    = 10;
    localparam int unsigned B_SECOND_FLAG     = 9;
    localparam int unsigned B_FIRST_FLAG      = 8;
    localparam int unsigned B_SECOND_SENS     = 7;
    localparam int unsigned B_SECOND_POL      = 6;
    localparam int unsigned B_SECOND_SRC_LO   = 2;

    // current_source_control fields
    localparam int unsigned B_TRIM_LO         = 10;
    localparam int unsigned B_RANGE_LO        = 8;

    // source select codes shared by both edges
    localparam logic [3:0] SRC_TIMER_ONE      = 4'h0;
    localparam logic [3:0] SRC_COMPARE_ONE    = 4'h1;
    localparam logic [3:0] SRC_PIN_TWO        = 4'h2;
    localparam logic [3:0] SRC_PIN_ONE        = 4'h3;
    localparam logic [3:0] SRC_PIN_LO         = 4'h4;
    localparam logic [3:0] SRC_COMP_LO        = 4'hD;
    // first edge: pins 3..8 at codes 4..9, captures at A..C
    localparam logic [3:0] SRC1_PIN_HI        = 4'h9;
    localparam logic [3:0] SRC1_CAP_LO        = 4'hA;
    localparam logic [3:0] SRC1_PIN_BASE      = 4'h2;
    // second edge: pins 9..13 at codes 4..8, captures at 9..B, C unused
    localparam logic [3:0] SRC2_PIN_HI        = 4'h8;
    localparam logic [3:0] SRC2_CAP_LO        = 4'h9;
    localparam logic [3:0] SRC2_UNUSED        = 4'hC;
    localparam logic [3:0] SRC2_PIN_BASE      = 4'h4;

    // current range codes and their power of ten over base
    localparam logic [1:0] RNG_BASE           = 2'h1;
    localparam logic [1:0] RNG_TEN            = 2'h2;
    localparam logic [1:0] RNG_HUNDRED        = 2'h3;
    localparam logic [1:0] RNG_THOUSAND       = 2'h0;
    localparam logic [1:0] DEC_ZERO           = 2'h0;
    localparam logic [1:0] DEC_ONE            = 2'h1;
    localparam logic [1:0] DEC_TWO            = 2'h2;
    localparam logic [1:0] DEC_THREE          = 2'h3;

    // delay generation sequencer
    typedef enum logic [1:0] {
        DG_IDLE   = 2'b00,
        DG_CHARGE = 2'b01,
        DG_FIRE   = 2'b10
    } ctec_dg_t;

endpackage

// File: ctec_edge_qual.sv
`timescale 1ns/100ps
`default_nettype none
// turns one selected source into a qualified event per clock
module ctec_edge_qual (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic source,
    input  wire logic edgeMode,
    input  wire logic risingPol,
    output logic      event_o
);
    typedef struct packed {
        logic prev;
    } ctec_eq_state_t;

    ctec_eq_state_t s_r;
    ctec_eq_state_t s_nxt;

    // remember the last sample for transition detection
    always_comb begin
        s_nxt      = s_r;
        s_nxt.prev = source;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // transition or level, rising/high or falling/low
    always_comb begin
        if (edgeMode) begin
            event_o = risingPol ? (source & ~s_r.prev) : (~source & s_r.prev);
        end else begin
            event_o = risingPol ? source : ~source;
        end
    end
endmodule // ctec_edge_qual
`default_nettype wire

// File: ctec_source_mux.sv
`timescale 1ns/100ps
`default_nettype none
// picks one trigger source for an edge channel from its select code
module ctec_source_mux #(
    parameter bit SECOND = 1'b0
) (
    input  wire logic [3:0]  select,
    input  wire logic        timerOne,
    input  wire logic        outputCompareOne,
    input  wire logic [12:0] externalEdgePin,
    input  wire logic [2:0]  inputCapture,
    input  wire logic [2:0]  comparatorOut,
    output logic             source
);
    // map a code to its source; the second channel has one dead code
    function automatic logic pick(input logic [3:0] code);
        logic [3:0] pinHi;
        logic [3:0] capLo;
        logic [3:0] pinBase;
        pinHi   = SECOND ? ctec_pkg::SRC2_PIN_HI : ctec_pkg::SRC1_PIN_HI;
        capLo   = SECOND ? ctec_pkg::SRC2_CAP_LO : ctec_pkg::SRC1_CAP_LO;
        pinBase = SECOND ? ctec_pkg::SRC2_PIN_BASE : ctec_pkg::SRC1_PIN_BASE;
        if (code == ctec_pkg::SRC_TIMER_ONE) begin
            pick = timerOne;
        end else if (code == ctec_pkg::SRC_COMPARE_ONE) begin
            pick = outputCompareOne;
        end else if (code == ctec_pkg::SRC_PIN_TWO) begin
            pick = externalEdgePin[1];
        end else if (code == ctec_pkg::SRC_PIN_ONE) begin
            pick = externalEdgePin[0];
        end else if (code <= pinHi) begin
            pick = SECOND ? externalEdgePin[code + pinBase] : externalEdgePin[code - pinBase];
        end else if (SECOND && code == ctec_pkg::SRC2_UNUSED) begin
            pick = 1'b0;
        end else if (code < ctec_pkg::SRC_COMP_LO) begin
            pick = inputCapture[2'(code - capLo)];
        end else begin
            pick = comparatorOut[2'(code - ctec_pkg::SRC_COMP_LO)];
        end
    endfunction

    assign source = pick(select);
endmodule // ctec_source_mux
`default_nettype wire

// File: ctec_edge_partner.sv
`timescale 1ns/100ps
`default_nettype none
// drives the peripheral edge sources and the delay comparator seen by the block
module ctec_edge_partner (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [4:0]  srcIdx,
    input  wire logic        srcLvl,
    input  wire logic [3:0]  tripCycles,
    input  wire logic        delayCharge,
    output logic             timerOne,
    output logic             outputCompareOne,
    output logic [12:0]      externalEdgePin,
    output logic [2:0]       inputCapture,
    output logic [2:0]       comparatorOut,
    output logic             delayTrip
);
    logic [20:0] lines;
    logic [3:0]  chargeCnt_r;

    // one source follows the requested level, every other source sits low
    always_comb begin
        lines = 21'h0;
        lines[srcIdx] = srcLvl;
    end

    // source order: timer, compare, pins 1..13, captures 1..3, comparators 1..3
    assign timerOne         = lines[0];
    assign outputCompareOne = lines[1];
    assign externalEdgePin  = lines[14:2];
    assign inputCapture     = lines[17:15];
    assign comparatorOut    = lines[20:18];

    // delay capacitor: trips after a chosen number of charging cycles
    always_ff @(posedge clock) begin
        if (reset || !delayCharge) begin
            chargeCnt_r <= 4'h0;
        end else if (chargeCnt_r != 4'hF) begin
            chargeCnt_r <= chargeCnt_r + 4'h1;
        end
    end
    assign delayTrip = delayCharge && (chargeCnt_r >= tripCycles);
endmodule // ctec_edge_partner
`default_nettype wire

// File: ctec_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// self-checking bench for the charge timing edge control block
module ctec_top_tb_top;
    logic        clock, reset, regWrite, regRead, deviceIdle, srcLvl, delayTrip;
    logic [1:0]  regAddr, currentRange, rangeDecade;
    logic [15:0] regWriteData, regReadData;
    logic [4:0]  srcIdx;
    logic [3:0]  tripCycles;
    logic        timerOne, outputCompareOne, currentSourceOn, currentDischarge, diodeRoute;
    logic        measurePulse, triggerOut, delayCharge, delayedPulseOutput;
    logic [12:0] externalEdgePin;
    logic [2:0]  inputCapture, comparatorOut;
    logic [5:0]  currentTrim;
    int          n_errors = 0;
    int          cmp_count = 0;

    ctec_top dut (.clock(clock), .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .deviceIdle(deviceIdle),
        .timerOne(timerOne), .outputCompareOne(outputCompareOne), .externalEdgePin(externalEdgePin),
        .inputCapture(inputCapture), .comparatorOut(comparatorOut), .delayTrip(delayTrip),
        .currentSourceOn(currentSourceOn), .currentDischarge(currentDischarge), .diodeRoute(diodeRoute),
        .currentTrim(currentTrim), .currentRange(currentRange), .rangeDecade(rangeDecade),
        .measurePulse(measurePulse), .triggerOut(triggerOut), .delayCharge(delayCharge),
        .delayedPulseOutput(delayedPulseOutput));
    ctec_edge_partner farSide (.clock(clock), .reset(reset), .srcIdx(srcIdx), .srcLvl(srcLvl),
        .tripCycles(tripCycles), .delayCharge(delayCharge), .timerOne(timerOne),
        .outputCompareOne(outputCompareOne), .externalEdgePin(externalEdgePin),
        .inputCapture(inputCapture), .comparatorOut(comparatorOut), .delayTrip(delayTrip));

    // free running clock
    always #5 clock = ~clock;

    // verdict and end of run
    task automatic results();
        if (n_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // compares one observed value with its expectation
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // register port write and read
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 d = regReadData;
    endtask

    // far side source level, then settle time
    task automatic src(input logic [4:0] i, input logic l, input int w);
        @(posedge clock);
        srcIdx <= i;
        srcLvl <= l;
        repeat (w) @(posedge clock);
        #1;
    endtask

    // partner line index for a select code
    function automatic logic [4:0] idxOf(input logic second, input logic [3:0] c);
        if (c < 4'h2) return {1'b0, c};
        if (c < 4'h4) return {1'b0, c ^ 4'h1};
        if (second) return {1'b0, c} + ((c < 4'hD) ? 5'h06 : 5'h05);
        return {1'b0, c} + ((c < 4'hA) ? 5'h00 : 5'h05);
    endfunction

    // reset values, masks and the unmapped index
    task automatic regTest();
        logic [15:0] d;
        logic [15:0] m [4] = '{ctec_pkg::MASK_CTL1, ctec_pkg::MASK_CTL2, ctec_pkg::MASK_ICON, 16'h0000};
        // the control register goes last so its enables cannot set flags early
        for (int a = 3; a >= 0; a--) begin
            rd(a[1:0], d);
            chk("resetValue", d, 16'h0000);
            wr(a[1:0], 16'hFFFF);
            rd(a[1:0], d);
            chk("writeMask", d, m[a]);
        end
    endtask

    // one source code, one polarity, edge mode
    task automatic edgeTrial(input logic second, input logic [3:0] code);
        logic        pol;
        logic [4:0]  i;
        logic [15:0] d;
        logic [15:0] w;
        pol = second ^ code[0];
        i = idxOf(second, code);
        // the other channel watches the timer for the opposite edge
        w = second ? {1'b1, !pol, 6'h00, 1'b1, pol, code, 2'h0} : {1'b1, pol, code, 3'h1, !pol, 6'h00};
        src(i, !pol, 2);
        wr(2'h1, w);
        wr(2'h1, w); // clears a flag that the old setup set at the first write
        src(i, pol, 2);
        chk("sourceOn", currentSourceOn, 16'h0001);
        chk("diodeRoute", diodeRoute, 16'h0000);
        chk("delayCharge", delayCharge, 16'h0000);
        rd(2'h1, d);
        chk("edgeFlags", d[9:8], second ? 16'h0002 : 16'h0001);
    endtask

    // enable, gate and idle qualification of the first edge
    task automatic blockTrial(input logic [15:0] ctl, input logic idle, input logic expSet);
        logic [15:0] d;
        wr(2'h0, ctl);
        deviceIdle <= idle;
        src(5'h00, 1'b0, 2);
        wr(2'h1, 16'hC000);
        src(5'h00, 1'b1, 2);
        rd(2'h1, d);
        chk("qualifiedFlag", d[8], expSet);
        deviceIdle <= 1'b0;
    endtask

    // level against transition sensitivity with the source held high
    task automatic levelTest();
        logic [15:0] d;
        wr(2'h0, 16'h8800);
        src(5'h00, 1'b1, 2);
        wr(2'h1, 16'h4000);
        src(5'h00, 1'b1, 2);
        rd(2'h1, d);
        chk("levelFirst", d[9:8], 16'h0001);
        wr(2'h1, 16'hC000);
        wr(2'h1, 16'hC000); // hardware set wins at the first write
        src(5'h00, 1'b1, 2);
        rd(2'h1, d);
        chk("edgeHeld", d[9:8], 16'h0000);
        wr(2'h1, 16'h0040);
        src(5'h00, 1'b1, 2);
        rd(2'h1, d);
        chk("levelSecond", d[9:8], 16'h0002);
    endtask

    // ordered edges, measurement pulse and trigger
    task automatic orderTest();
        logic [15:0] d;
        wr(2'h0, 16'h8D00);
        src(5'h01, 1'b0, 2);
        wr(2'h1, 16'hC0C4);
        wr(2'h1, 16'hC0C4); // hardware set wins at the first write
        src(5'h01, 1'b1, 2);
        rd(2'h1, d);
        chk("earlySecond", d[9:8], 16'h0000);
        src(5'h00, 1'b1, 3);
        chk("measurePulse", measurePulse, 16'h0001);
        src(5'h01, 1'b1, 1);
        chk("triggerOut", triggerOut, 16'h0001);
        chk("bothRoute", {currentSourceOn, diodeRoute}, 16'h0001);
        @(posedge clock);
        #1 chk("pulseEnds", {measurePulse, triggerOut}, 16'h0000);
        rd(2'h1, d);
        chk("bothFlags", d[9:8], 16'h0003);
    endtask

    // software flag writes, discharge, trim and range outputs
    task automatic swTest();
        logic [7:0] t [4] = '{8'h7D, 8'h02, 8'hFF, 8'h84};
        wr(2'h0, 16'h8200);
        #1 chk("discharge", currentDischarge, 16'h0001);
        for (int k = 0; k < 4; k++) begin
            wr(2'h1, {6'h00, k[1:0], 8'h00});
            #1 chk("swSource", {currentSourceOn, diodeRoute}, (k == 1 || k == 2) ? 16'h0002 : 16'h0001);
            wr(2'h2, {t[k], 8'h00});
            #1 chk("trimRange", {currentTrim, currentRange}, t[k]);
            chk("decade", rangeDecade, k[1:0]);
        end
    endtask

    // delayed pulse after trip of the charged capacitor
    task automatic delayTest();
        int n;
        wr(2'h1, 16'hC000);
        src(5'h00, 1'b0, 2);
        wr(2'h0, 16'h9800);
        src(5'h00, 1'b1, 2);
        chk("charging", delayCharge, 16'h0001);
        n = 0;
        while (delayedPulseOutput !== 1'b1 && n < 20) begin
            @(posedge clock);
            #1 n++;
        end
        chk("delayPulse", {delayedPulseOutput, delayCharge}, 16'h0002);
        chk("delayCycles", n[15:0], {12'h000, tripCycles});
        @(posedge clock);
        #1 chk("pulseOnce", delayedPulseOutput, 16'h0000);
    endtask

    // main sequence
    initial begin
        clock = 1'b0;
        reset = 1'b1;
        {regAddr, regWriteData, regWrite, regRead, deviceIdle, srcIdx, srcLvl} = '0;
        tripCycles = 4'h3;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        regTest();
        levelTest();
        for (int s = 0; s < 2; s++)
            for (int c = 0; c < 16; c++)
                if (!(s == 1 && c == 12)) edgeTrial(s[0], c[3:0]);
        blockTrial(16'h0800, 1'b0, 1'b0);
        blockTrial(16'h8000, 1'b0, 1'b0);
        blockTrial(16'hA800, 1'b1, 1'b0);
        blockTrial(16'hA800, 1'b0, 1'b1);
        blockTrial(16'h8800, 1'b1, 1'b1);
        orderTest();
        swTest();
        delayTest();
        results();
    end

    // watchdog well beyond the expected run length
    initial begin
        #100000;
        n_errors++;
        results();
    end
endmodule // ctec_top_tb_top
`default_nettype wire
